// >>> common/abx_map.vh
// Contract
// RULE_01: Add-immediate: acc plus literal; sets carry, half-carry, zero.
// RULE_02: And-immediate: acc AND literal; only the zero flag changes.
// RULE_03: Add-register: acc plus file reg; sets carry, half-carry, zero.
// RULE_04: Register add/AND: target bit 0 writes acc, 1 writes file reg.
// RULE_05: And-register: acc AND file reg, routed by target bit; zero only.
// RULE_06: Bit-clear clears one bit of a file register; flags unchanged.
// RULE_07: Each instruction completes in one cycle of four clock periods.
// RULE_08: Zero flag on zero result; carry from bit 7, half from bit 3.
`ifndef ABX_MAP_VH
`define ABX_MAP_VH

// Register byte offsets.
`define ABX_OFF_INSTR 12'h000
`define ABX_OFF_ACC 12'h004
`define ABX_OFF_FLAGS 12'h008
`define ABX_OFF_FINDEX 12'h00c
`define ABX_OFF_FDATA 12'h010
`define ABX_OFF_STATUS 12'h014

// Flag register bit positions.
`define ABX_FLAG_CARRY 0
`define ABX_FLAG_HALF 1
`define ABX_FLAG_ZERO 2

// Status register bit positions.
`define ABX_STAT_BUSY 0
`define ABX_STAT_UNSUP 1

// Reset values.
`define ABX_RST_ACC 8'h00
`define ABX_RST_FLAGS 3'h0
`define ABX_RST_INSTR 14'h0000

// Opcode prefixes.
`define ABX_OP_ADD_IMM 5'h1f
`define ABX_OP_AND_IMM 6'h39
`define ABX_OP_ADD_REG 6'h07
`define ABX_OP_AND_REG 6'h05
`define ABX_OP_BIT_CLR 4'h4

// Clock periods per instruction cycle.
`define ABX_CYCLE_CLKS 4

// AXI responses.
`define ABX_RESP_OKAY 2'h0
`define ABX_RESP_SLVERR 2'h2

`endif

// >>> rtl/abx_exec.v
`timescale 1ns/100ps
`include "abx_map.vh"

module abx_exec #(
    parameter ADDR_W = 12,
    parameter FILE_DEPTH = 128
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    reg [7:0] file_mem [0:FILE_DEPTH-1];
    reg [7:0] accumulator_q;
    reg [2:0] flags_q;
    reg [13:0] instr_q;
    reg [6:0] findex_q;
    reg pending_q;
    reg unsup_q;
    reg [1:0] phase_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    // The slot count is held as a word and cut to the divider's width.
    wire [31:0] last_phase = `ABX_CYCLE_CLKS - 1;
    wire cycle_en = (phase_q == last_phase[1:0]);
    wire exec_en = cycle_en & pending_q;

    // Byte-lane merge honouring write strobes.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle divider: one execute slot every four clocks.

    always @(posedge aclk)
    begin
        if (!aresetn)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1; // [RULE_07]
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath.

    wire [6:0] register_operand = instr_q[6:0];
    wire target_select_bit = instr_q[7];
    wire [2:0] position_index = instr_q[9:7];
    wire [7:0] immediate_operand = instr_q[7:0];
    wire [7:0] file_val = file_mem[register_operand];

    wire is_add_imm = (instr_q[13:9] == `ABX_OP_ADD_IMM);
    wire is_and_imm = (instr_q[13:8] == `ABX_OP_AND_IMM);
    wire is_add_reg = (instr_q[13:8] == `ABX_OP_ADD_REG);
    wire is_and_reg = (instr_q[13:8] == `ABX_OP_AND_REG);
    wire is_bit_clr = (instr_q[13:10] == `ABX_OP_BIT_CLR);
    wire is_reg_op = is_add_reg | is_and_reg;
    wire is_add = is_add_imm | is_add_reg;

    wire [7:0] opnd = is_reg_op ? file_val : immediate_operand;
    wire [8:0] sum = {1'b0, accumulator_q} + {1'b0, opnd}; // [RULE_08]
    wire [4:0] half = {1'b0, accumulator_q[3:0]} + {1'b0, opnd[3:0]};
    wire [7:0] land = accumulator_q & opnd;
    wire [7:0] result = is_add ? sum[7:0] : land;
    wire [7:0] clr_val = file_val & ~(8'h01 << position_index); // [RULE_06]

    // Register ops with target bit set, and bit-clear, write the file.
    wire file_wr = exec_en & ((is_reg_op & target_select_bit) | is_bit_clr);
    wire acc_wr = exec_en & (is_add_imm | is_and_imm |
                  (is_reg_op & ~target_select_bit)); // [RULE_04]

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side.

    wire aw_have = ~s_axi_awready;
    wire w_have = ~s_axi_wready;
    wire wr_go = aw_have & w_have & ~s_axi_bvalid;
    wire [31:0] wd_acc = merge({24'h0, accumulator_q}, wdata_q, wstrb_q);
    wire [31:0] wd_flags = merge({29'h0, flags_q}, wdata_q, wstrb_q);
    wire [31:0] wd_instr = merge({18'h0, instr_q}, wdata_q, wstrb_q);
    wire [31:0] wd_fidx = merge({25'h0, findex_q}, wdata_q, wstrb_q);
    wire [31:0] wd_fdat = merge({24'h0, file_mem[findex_q]}, wdata_q,
                                wstrb_q);
    wire wr_map = (awaddr_q == `ABX_OFF_INSTR) |
                  (awaddr_q == `ABX_OFF_ACC) |
                  (awaddr_q == `ABX_OFF_FLAGS) |
                  (awaddr_q == `ABX_OFF_FINDEX) |
                  (awaddr_q == `ABX_OFF_FDATA) |
                  (awaddr_q == `ABX_OFF_STATUS);
    // Software writes to core state are dropped while an instruction waits,
    // so the execute slot never races a bus write.
    wire sw_wr = wr_go & ~pending_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ABX_RESP_OKAY;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
            end
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core registers: execute slot or software write.

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            accumulator_q <= `ABX_RST_ACC;
            flags_q <= `ABX_RST_FLAGS;
            instr_q <= `ABX_RST_INSTR;
            findex_q <= 7'h00;
            pending_q <= 1'b0;
            unsup_q <= 1'b0;
        end
        else if (exec_en)
        begin
            pending_q <= 1'b0; // [RULE_07]
            unsup_q <= ~(is_add | is_and_imm | is_and_reg | is_bit_clr);
            if (acc_wr)
                accumulator_q <= result; // [RULE_01] [RULE_02] [RULE_03]
            if (is_add)
            begin
                flags_q[`ABX_FLAG_CARRY] <= sum[8]; // [RULE_01] [RULE_03]
                flags_q[`ABX_FLAG_HALF] <= half[4]; // [RULE_08]
            end
            // Only the AND ops touch zero besides the adds.
            if (is_add | is_and_imm | is_and_reg)
                flags_q[`ABX_FLAG_ZERO] <= (result == 8'h00); // [RULE_05]
        end
        else if (sw_wr)
        begin
            if (awaddr_q == `ABX_OFF_INSTR)
            begin
                instr_q <= wd_instr[13:0];
                pending_q <= 1'b1;
            end
            if (awaddr_q == `ABX_OFF_ACC)
                accumulator_q <= wd_acc[7:0];
            if (awaddr_q == `ABX_OFF_FLAGS)
                flags_q <= wd_flags[2:0];
            if (awaddr_q == `ABX_OFF_FINDEX)
                findex_q <= wd_fidx[6:0];
        end
    end

    // File registers hold no control state and are left unreset.
    always @(posedge aclk)
    begin
        if (file_wr)
            file_mem[register_operand] <= is_bit_clr ? clr_val
                                                     : result; // [RULE_04]
        else if (sw_wr & (awaddr_q == `ABX_OFF_FDATA))
            file_mem[findex_q] <= wd_fdat[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side.

    reg [31:0] rd_mux;
    reg rd_ok;

    always @*
    begin
        rd_mux = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `ABX_OFF_INSTR: rd_mux = {18'h0, instr_q};
            `ABX_OFF_ACC: rd_mux = {24'h0, accumulator_q};
            `ABX_OFF_FLAGS: rd_mux = {29'h0, flags_q};
            `ABX_OFF_FINDEX: rd_mux = {25'h0, findex_q};
            `ABX_OFF_FDATA: rd_mux = {24'h0, file_mem[findex_q]};
            `ABX_OFF_STATUS: rd_mux = {30'h0, unsup_q, pending_q};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ABX_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
            end
            if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // abx_exec

// >>> verification/abx_exec_asserts.sv
`timescale 1ns/100ps
module abx_chk #(
    parameter ADDR_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("b late");
    AST_AW_LOW: assert property (s_axi_awvalid && s_axi_awready
        |=> !s_axi_awready && !s_axi_bvalid) else $error("aw not closed");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    AST_B_END: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("b end");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("r late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    AST_R_END: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("r end");
    AST_R_ERR: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 12'h014 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read");
    AST_R_OK: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr <= 12'h014 && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == 2'h0) else $error("mapped read");
    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h014);
endmodule // abx_chk
//////////////////////////////////////////////////////////////////////////////
bind abx_exec abx_chk #(.ADDR_W(ADDR_W)) i_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`include "abx_map.vh"
module tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors, n_checks;

    abx_exec i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Ready is delayed on purpose so the response is seen standing unserved.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            ad |= s_axi_awready;
            wd |= s_axi_wready;
        end
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
    endtask

    // Read data is taken at the address edge, so wait out one full slot
    // before asking whether busy has cleared.
    task automatic ex(input logic [13:0] i);
        wr(`ABX_OFF_INSTR, {18'h0, i}, `ABX_RESP_OKAY);
        repeat (`ABX_CYCLE_CLKS) @(posedge aclk);
        rc(`ABX_OFF_STATUS, 32'h0);
    endtask

    task finish_test;
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end

    initial
    begin
        #200us;
        num_errors++;
        finish_test;
    end

    initial
    begin
        aresetn = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`ABX_OFF_ACC, 32'h0);
        rc(`ABX_OFF_FLAGS, 32'h0);
        wr(`ABX_OFF_FINDEX, 32'h42, `ABX_RESP_OKAY);
        wr(`ABX_OFF_ACC, 32'h8f, `ABX_RESP_OKAY);
        ex(14'h3f71);
        rc(`ABX_OFF_ACC, 32'h0);
        rc(`ABX_OFF_FLAGS, 32'h7);
        ex(14'h3e15);
        rc(`ABX_OFF_ACC, 32'h15);
        rc(`ABX_OFF_FLAGS, 32'h0);
        wr(`ABX_OFF_ACC, 32'ha3, `ABX_RESP_OKAY);
        wr(`ABX_OFF_FLAGS, 32'h3, `ABX_RESP_OKAY);
        ex(14'h395f);
        rc(`ABX_OFF_ACC, 32'h3);
        rc(`ABX_OFF_FLAGS, 32'h3);
        ex(14'h3900);
        rc(`ABX_OFF_FLAGS, 32'h7);
        wr(`ABX_OFF_FDATA, 32'hc2, `ABX_RESP_OKAY);
        wr(`ABX_OFF_ACC, 32'h17, `ABX_RESP_OKAY);
        ex(14'h0742);
        rc(`ABX_OFF_ACC, 32'hd9);
        rc(`ABX_OFF_FLAGS, 32'h0);
        rc(`ABX_OFF_FDATA, 32'hc2);
        ex(14'h07c2);
        rc(`ABX_OFF_ACC, 32'hd9);
        rc(`ABX_OFF_FDATA, 32'h9b);
        rc(`ABX_OFF_FLAGS, 32'h1);
        ex(14'h05c2);
        rc(`ABX_OFF_FDATA, 32'h99);
        wr(`ABX_OFF_ACC, 32'h66, `ABX_RESP_OKAY);
        ex(14'h0542);
        rc(`ABX_OFF_ACC, 32'h0);
        rc(`ABX_OFF_FLAGS, 32'h5);
        wr(`ABX_OFF_FDATA, 32'hc7, `ABX_RESP_OKAY);
        ex(14'h13c2);
        rc(`ABX_OFF_FDATA, 32'h47);
        rc(`ABX_OFF_FLAGS, 32'h5);
        wr(`ABX_OFF_INSTR, 32'h0, `ABX_RESP_OKAY);
        repeat (4) @(posedge aclk);
        rc(`ABX_OFF_STATUS, 32'h2);
        wr(`ABX_OFF_STATUS, 32'h0, `ABX_RESP_OKAY);
        rc(`ABX_OFF_STATUS, 32'h2);
        wr(12'h018, 32'h1, `ABX_RESP_SLVERR);
        rc(12'h018, 32'h0);
        finish_test;
    end
endmodule // tb_top
